// *** pkg/cbwd_map.svh ***
/*
 * Timing constants and counts for the CAN bus wake detector.
 * Assumes a 250 MHz core clock (4 ns period).
 */
`ifndef CBWD_MAP_SVH
`define CBWD_MAP_SVH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define CBWD_CLK_PERIOD_PS       4000

// ----------------------------------------------------------------------------
// Times in their own units and derived cycle counts
// ----------------------------------------------------------------------------
`define CBWD_PULSE_MIN_NS        500
`define CBWD_PULSE_MAX_US        500
`define CBWD_GAP_MAX_US          500
`define CBWD_CAN_NORMAL_MAX_US   10
`define CBWD_INT_PULSE_US        10
// Least width rounds up; longest times round down.
`define CBWD_PULSE_MIN_CYC  ((`CBWD_PULSE_MIN_NS * 1000 + `CBWD_CLK_PERIOD_PS - 1) / `CBWD_CLK_PERIOD_PS)
`define CBWD_PULSE_MAX_CYC  ((`CBWD_PULSE_MAX_US * 1000000) / `CBWD_CLK_PERIOD_PS)
`define CBWD_GAP_MAX_CYC    ((`CBWD_GAP_MAX_US * 1000000) / `CBWD_CLK_PERIOD_PS)
`define CBWD_INT_PULSE_CYC  ((`CBWD_INT_PULSE_US * 1000000) / `CBWD_CLK_PERIOD_PS)

// ----------------------------------------------------------------------------
// Wake counting
// ----------------------------------------------------------------------------
`define CBWD_WAKE_PULSES         2'h3
`define CBWD_CNT_W               18

`endif

// *** pkg/cbwd_pkg.sv ***
/*
 * Types for the CAN bus wake detector.
 * Assumes cbwd_map.svh supplies the numeric constants.
 */
package cbwd_pkg;

    // Gray-coded along idle -> width measuring -> gap waiting.
    typedef enum logic [1:0]
    {
        CBWD_IDLE  = 2'h0,
        CBWD_PULSE = 2'h1,
        CBWD_GAP   = 2'h3
    } cbwd_state_type;

endpackage

// *** core/cbwd_detector.sv ***
/*
 * CAN transceiver digital core: transmit/receive mapping and the bus wake
 * detector with width filter, pulse counter, gap timeout and stop-mode pulse.
 * Assumes all inputs are synchronous to clock_i; the low-power receiver
 * output is high while the bus is dominant.
 */
`timescale 1ns/1ps
`include "cbwd_map.svh"

// How it works
// - Accept a wake-receiver pulse only if wider than 0.5 us and under 500 us.
// - A discarded pulse clears the pulse counter and gives no wake.
// - Each accepted pulse counts up; three accepted pulses assert wake.
// - More than 500 us between accepted pulses clears the counter, no wake.
// - Wake flag holds until CAN normal mode is entered, which clears it.
// - A software disable setting blocks any CAN wake signal.
// - Drive bus dominant while transmit is low, recessive while high.
// - Receive output low while bus dominant, high while recessive.
// - CAN normal mode follows its command within at most 10 us.
// - In stop mode a wake event gives an interrupt low pulse of about 10 us.
module cbwd_detector
(
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic resetn_i,
    // Protocol handler side
    input  wire logic tx_i,
    output logic      rx_o,
    // Bus side
    output logic      bus_dominant_o,
    input  wire logic bus_dominant_i,
    input  wire logic low_power_bus_receiver_i,
    // Mode control
    input  wire logic can_normal_req_i,
    input  wire logic wake_disable_i,
    input  wire logic stop_mode_i,
    // Status
    output logic      can_normal_o,
    output logic      wake_o,
    output logic      intn_o
);

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    cbwd_pkg::cbwd_state_type  state_r, state_nxt;
    logic [`CBWD_CNT_W-1:0]    timer_r, timer_nxt;
    logic [1:0]                count_r, count_nxt;
    logic                      wake_r, wake_nxt;
    logic                      normal_r, normal_nxt;
    logic                      rx_r, rx_nxt;
    logic                      dom_r, dom_nxt;
    logic [`CBWD_CNT_W-1:0]    int_cnt_r, int_cnt_nxt;
    logic                      intn_r, intn_nxt;
    logic                      wake_set;

    // ------------------------------------------------------------------------
    // Transceiver mapping and mode
    // ------------------------------------------------------------------------
    // Registered one cycle: well inside the loop delay budget.
    always_comb
    begin
        dom_nxt    = ~tx_i;
        rx_nxt     = ~bus_dominant_i;
        normal_nxt = can_normal_req_i;
    end

    // ------------------------------------------------------------------------
    // Wake detector
    // ------------------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        timer_nxt = timer_r;
        count_nxt = count_r;
        wake_set  = 1'b0;
        case (state_r)
            cbwd_pkg::CBWD_IDLE:
            begin
                timer_nxt = '0;
                if (low_power_bus_receiver_i)
                begin
                    state_nxt = cbwd_pkg::CBWD_PULSE;
                    timer_nxt = `CBWD_CNT_W'(1);
                end
            end
            cbwd_pkg::CBWD_PULSE:
            begin
                // The timer parks at the upper limit, so a bus held dominant
                // can never wrap back into the accepted band.
                if (low_power_bus_receiver_i)
                begin
                    if (timer_r < `CBWD_CNT_W'(`CBWD_PULSE_MAX_CYC))
                    begin
                        timer_nxt = timer_r + `CBWD_CNT_W'(1);
                    end
                end
                else if (timer_r > `CBWD_CNT_W'(`CBWD_PULSE_MIN_CYC)
                         && timer_r < `CBWD_CNT_W'(`CBWD_PULSE_MAX_CYC))
                begin
                    state_nxt = cbwd_pkg::CBWD_GAP;
                    timer_nxt = '0;
                    if (count_r == `CBWD_WAKE_PULSES - 2'h1)
                    begin
                        wake_set  = 1'b1;
                        count_nxt = '0;
                    end
                    else
                    begin
                        count_nxt = count_r + 2'h1;
                    end
                end
                else
                begin
                    count_nxt = '0;
                    state_nxt = cbwd_pkg::CBWD_IDLE;
                    timer_nxt = '0;
                end
            end
            cbwd_pkg::CBWD_GAP:
            begin
                // A new pulse wins over the timeout in the same cycle; only a
                // full quiet span clears the count.
                if (low_power_bus_receiver_i)
                begin
                    state_nxt = cbwd_pkg::CBWD_PULSE;
                    timer_nxt = `CBWD_CNT_W'(1);
                end
                else if (timer_r >= `CBWD_CNT_W'(`CBWD_GAP_MAX_CYC))
                begin
                    count_nxt = '0;
                    state_nxt = cbwd_pkg::CBWD_IDLE;
                    timer_nxt = '0;
                end
                else
                begin
                    timer_nxt = timer_r + `CBWD_CNT_W'(1);
                end
            end
            default:
            begin
                state_nxt = cbwd_pkg::CBWD_IDLE;
                timer_nxt = '0;
                count_nxt = '0;
            end
        endcase
        // Disabled wake or normal mode keeps the counter parked at zero.
        if (wake_disable_i || normal_r)
        begin
            count_nxt = '0;
            wake_set  = 1'b0;
        end
        // Normal mode ends the wake cycle; a fresh wake never coincides
        // with it because counting is held off while normal is active.
        wake_nxt = wake_r;
        if (normal_r)
        begin
            wake_nxt = 1'b0;
        end
        if (wake_set)
        begin
            wake_nxt = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Stop-mode interrupt pulse
    // ------------------------------------------------------------------------
    always_comb
    begin
        int_cnt_nxt = int_cnt_r;
        if (wake_set && stop_mode_i)
        begin
            int_cnt_nxt = `CBWD_CNT_W'(`CBWD_INT_PULSE_CYC);
        end
        else if (int_cnt_r != '0)
        begin
            int_cnt_nxt = int_cnt_r - `CBWD_CNT_W'(1);
        end
        // Registered so the interrupt pin never shows a decode glitch.
        intn_nxt = (int_cnt_nxt == '0);
    end

    // ------------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_r   <= cbwd_pkg::CBWD_IDLE;
            timer_r   <= '0;
            count_r   <= '0;
            wake_r    <= 1'b0;
            normal_r  <= 1'b0;
            rx_r      <= 1'b1;
            dom_r     <= 1'b0;
            int_cnt_r <= '0;
            intn_r    <= 1'b1;
        end
        else
        begin
            state_r   <= state_nxt;
            timer_r   <= timer_nxt;
            count_r   <= count_nxt;
            wake_r    <= wake_nxt;
            normal_r  <= normal_nxt;
            rx_r      <= rx_nxt;
            dom_r     <= dom_nxt;
            int_cnt_r <= int_cnt_nxt;
            intn_r    <= intn_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign bus_dominant_o = dom_r;
    assign rx_o           = rx_r;
    assign can_normal_o   = normal_r;
    assign wake_o         = wake_r;
    assign intn_o         = intn_r;

endmodule

// *** verification/cbwd_bus_model.sv ***
/* Bus model: other nodes and the wired bus.
   Assumes the bench moves other_dom_i at falling edges. */
`timescale 1ns/1ps
module cbwd_bus_model
(
    // Node drives
    input  wire logic drive_dom_i,
    input  wire logic other_dom_i,
    // Bus state
    output logic      bus_dom_o,
    output logic      wake_rx_o
);
    // Dominant wins, so a stuck driver shows up on receive.
    assign bus_dom_o = drive_dom_i | other_dom_i;
    assign wake_rx_o = bus_dom_o;
endmodule

// *** verification/cbwd_assertions.sv ***
/* Port checker for the wake detector.
   Assumes a bind onto cbwd_detector. */
`timescale 1ns/1ps
module cbwd_assertions
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic resetn_i,
    // Watched ports
    input wire logic tx_i,
    input wire logic rx_o,
    input wire logic bus_dominant_o,
    input wire logic bus_dominant_i,
    input wire logic low_power_bus_receiver_i,
    input wire logic can_normal_req_i,
    input wire logic wake_disable_i,
    input wire logic stop_mode_i,
    input wire logic can_normal_o,
    input wire logic wake_o,
    input wire logic intn_o
);
    logic [31:0] wid_r;
    logic [31:0] low_r;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // ------------------------------------------------------------
    // Run counters
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge resetn_i)
        if (!resetn_i)
            {wid_r, low_r} <= '0;
        else
            {wid_r, low_r} <= {low_power_bus_receiver_i ? wid_r + 32'h1 : 32'h0,
                               intn_o ? 32'h0 : low_r + 32'h1};
    sequence s_runt_end;
        !low_power_bus_receiver_i && wid_r > 32'h0 && wid_r <= 32'h7d;
    endsequence
    property p_tx; 1'b1 |=> bus_dominant_o == !$past(tx_i); endproperty
    a_tx: assert property (p_tx) else $error("bus drive wrong");
    property p_rx; 1'b1 |=> rx_o == !$past(bus_dominant_i); endproperty
    a_rx: assert property (p_rx) else $error("receive wrong");
    property p_norm; can_normal_req_i |=> can_normal_o; endproperty
    a_norm: assert property (p_norm) else $error("normal late");
    property p_hold; wake_o && !can_normal_o |=> wake_o; endproperty
    a_hold: assert property (p_hold) else $error("wake lost");
    property p_clr; can_normal_o |=> !wake_o; endproperty
    a_clr: assert property (p_clr) else $error("wake kept");
    property p_dis; wake_disable_i |=> !$rose(wake_o); endproperty
    a_dis: assert property (p_dis) else $error("wake while disabled");
    property p_runt; s_runt_end |=> !$rose(wake_o); endproperty
    a_runt: assert property (p_runt) else $error("runt woke");
    property p_int; $rose(intn_o) |-> low_r == 32'h9c4; endproperty
    a_int: assert property (p_int) else $error("int width wrong");
    property p_nostop; !stop_mode_i |=> !$fell(intn_o); endproperty
    a_nostop: assert property (p_nostop) else $error("int outside stop");
    property p_stopint; $rose(wake_o) && $past(stop_mode_i) |-> !intn_o; endproperty
    a_stopint: assert property (p_stopint) else $error("int missing");
endmodule
bind cbwd_detector cbwd_assertions u_chk (.clock_i(clock_i), .resetn_i(resetn_i),
    .tx_i(tx_i), .rx_o(rx_o), .bus_dominant_o(bus_dominant_o),
    .bus_dominant_i(bus_dominant_i), .low_power_bus_receiver_i(low_power_bus_receiver_i),
    .can_normal_req_i(can_normal_req_i), .wake_disable_i(wake_disable_i),
    .stop_mode_i(stop_mode_i), .can_normal_o(can_normal_o), .wake_o(wake_o),
    .intn_o(intn_o));

// *** verification/testbench.sv ***
/* Self-checking bench for the wake detector.
   Assumes the bus model and checker are compiled first. */
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic tx = 1'b1;
    logic other = 1'b0;
    logic req = 1'b0;
    logic dis = 1'b0;
    logic stop = 1'b1;
    logic rx, drv, bus, lp, norm, wake, intn;
    int bad_count = 0;
    int compares = 0;
    int seed = 32'h5a78c999;
    int cnt = 0;
    int widths[5] = '{126, 126, 125, 126, 126};
    always #2 clk = ~clk;
    cbwd_detector dut (.clock_i(clk), .resetn_i(rst_n), .tx_i(tx), .rx_o(rx),
        .bus_dominant_o(drv), .bus_dominant_i(bus), .low_power_bus_receiver_i(lp),
        .can_normal_req_i(req), .wake_disable_i(dis), .stop_mode_i(stop),
        .can_normal_o(norm), .wake_o(wake), .intn_o(intn));
    cbwd_bus_model u_bus (.drive_dom_i(drv), .other_dom_i(other), .bus_dom_o(bus),
        .wake_rx_o(lp));
    function automatic bit accepted(input int w);
        return w > 125 && w < 125000;
    endfunction
    task automatic check(input logic [4:0] seen, input logic [4:0] exp, input string what);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic pulse(input int w);
        other = 1'b1;
        repeat (w) @(negedge clk);
        other = 1'b0;
        repeat (4) @(negedge clk);
        cnt = accepted(w) ? cnt + 1 : 0;
    endtask
    task automatic print_verdict;
        if (bad_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Hang guard, far beyond the roughly 4300 to 6700 cycles of the run.
    initial
    begin
        #200000;
        bad_count++;
        print_verdict();
    end
    initial
    begin
        repeat (16) @(negedge clk);
        check({rx, drv, norm, wake, intn}, 5'h11, "reset");
        rst_n = 1'b1;
        repeat (40)
        begin
            tx = 1'($random(seed));
            other = 1'($random(seed));
            repeat (2) @(negedge clk);
            check(drv, !tx, "drive");
            check(rx, tx & !other, "receive");
        end
        {tx, other} = 2'h2;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 40 && cnt < 3; i++)
        begin
            // Late pulses are fixed at an accepted width so a wake always comes.
            pulse(i < 5 ? widths[i] : i > 20 ? 126 : 120 + {$random(seed)} % 12);
            check(wake, cnt == 3, "wake");
        end
        check(intn, 1'b0, "int low");
        repeat (2496) @(negedge clk);
        check(intn, 1'b0, "int held");
        @(negedge clk);
        check(intn, 1'b1, "int end");
        // One accepted pulse is left counted so the normal-mode clear shows.
        pulse(126);
        req = 1'b1;
        @(negedge clk);
        check(norm, 1'b1, "normal");
        @(negedge clk);
        check(wake, 1'b0, "wake clear");
        {req, stop} = 2'h0;
        repeat (2) pulse(126);
        check(wake, 1'b0, "restart");
        pulse(126);
        check(wake, 1'b1, "rewake");
        check(intn, 1'b1, "no int");
        req = 1'b1;
        repeat (2) @(negedge clk);
        check(wake, 1'b0, "wake clear again");
        {req, dis} = 2'h1;
        repeat (3) pulse(126);
        check(wake, 1'b0, "disabled");
        print_verdict();
    end
endmodule
